// ### hdl/mseq_top.sv
// Microprogram sequencer with host FIFO, status register and APB slave.
// Assumes host pins are asynchronous and pass through two-flop synchronisers.
//
// What this block does
// - 1K x 64 store, one instruction per clock
// - Reset starts execution at address zero
// - Word splits into next-address, output, operation fields
// - Enabled external rising edges vector 008-00B
// - Internal interrupts four-seven vector 00C-00F
// - Test one condition or sixteen-way case
// - Case groups: cc low, cc high, alu, misc
// - Status bit11 security, bit10 scan, 12-15 reserved
// - Status bits 7-4 carry, zero, overflow, sign
// - Status 3 stack full, 2 break, 1 bcz, 0 aco
// - Loop loads counter, repeats until it reaches one
// - Fifteen-entry stack holds return addresses
// - Nested loops push and pop counter
// - Stack full sets flag, raises interrupt seven
// - Breakpoint match raises interrupt six, sets flag
// - FIFO eight entries of 22 bits
// - Command entry redirects to its low ten bits
// - Mismatched consumption sets exception flag bit 9
// - Data input register captures while enabled only
// - Output register drives bus when idle, select 01
// - Input and output ready flags, ready on pin
// - Control bit 7 enables data input capture
// - Control bits 6-5 choose host bus source
`timescale 1ns/1ps
module mseq_top #(
  parameter int unsigned FIFO_DEPTH = mseq_pkg::FIFO_DEPTH,
  parameter int unsigned STACK_DEPTH = mseq_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host bus
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic [4:0] host_addr_lines,
  input wire logic host_cmd_flag_line,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic gpio7_fifo_in_ready,
  // Interrupts, conditions and datapath flags
  input wire logic [3:0] ext_irq,
  input wire logic [7:0] cond_inputs,
  input wire logic int_irq_a,
  input wire logic int_irq_b,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic overflow_flag,
  input wire logic sign_flag,
  input wire logic block_count_zero,
  input wire logic addr_count_all_ones,
  input wire logic security_on,
  input wire logic scan_mode_on,
  input wire logic [15:0] data_in,
  // Instruction fields and FIFO output
  output logic [9:0] pc,
  output logic [9:0] out_ctrl,
  output logic [29:0] op_field,
  output logic [15:0] data_in_reg,
  output logic [15:0] fifo_out_data,
  output logic [4:0] fifo_out_addr,
  output logic fifo_out_ready,
  output logic fifo_in_ready
);
  initial begin
    if (FIFO_DEPTH != 8 || STACK_DEPTH < 2 || STACK_DEPTH > 15) $error("Unsupported depth");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and synchronisers
  logic [63:0] prog_mem [mseq_pkg::PROG_DEPTH];
  logic [21:0] fifo_mem [FIFO_DEPTH];
  logic [9:0] stack_mem [STACK_DEPTH];
  logic [3:0] sp;
  logic [2:0] wr_ptr, rd_ptr;
  logic [3:0] fifo_count;
  logic [15:0] loop_count;
  logic [9:0] brk_addr;
  logic [3:0] irq_en;
  logic [9:0] prog_addr;
  logic [31:0] prog_lo;
  logic [15:0] data_out_reg;
  logic fifo_exception_flag, stack_full_flag, brk_flag, in_irq;
  logic [3:0] ext_s1, ext_s2, ext_s3;
  logic [2:0] hs1, hs2, hs3;
  logic [21:0] hd1, hd2;
  logic [63:0] instr;
  logic [23:0] na_field;
  logic [9:0] target;
  logic [3:0] case_val;
  logic cond_bit;
  logic [9:0] next_pc;
  logic [7:0] irq_pend;
  logic host_wr_pulse, fifo_pop, fifo_push;
  logic [15:0] status_word;
  mseq_pkg::mseq_op_type na_op;
  logic apb_wr, apb_rd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= 4'h0;
      ext_s2 <= 4'h0;
      ext_s3 <= 4'h0;
      hs1 <= 3'h7;
      hs2 <= 3'h7;
      hs3 <= 3'h7;
      hd1 <= 22'h000000;
      hd2 <= 22'h000000;
    end else begin
      ext_s1 <= ext_irq;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      hs1 <= {host_select_n, host_read_n, host_write_n};
      hs2 <= hs1;
      hs3 <= hs2;
      hd1 <= {host_cmd_flag_line, host_addr_lines, host_data_in};
      hd2 <= hd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fetch and field split
  assign instr = prog_mem[pc];
  assign na_field = instr[mseq_pkg::NA_LSB +: 24];
  assign out_ctrl = instr[mseq_pkg::OC_LSB +: 10];
  assign op_field = instr[mseq_pkg::OP_LSB +: 30];
  assign na_op = mseq_pkg::mseq_op_type'(na_field[3:0]);
  assign target = na_field[mseq_pkg::TGT_LSB +: 10];
  assign cond_bit = cond_inputs[na_field[mseq_pkg::CSEL_LSB +: 3]];

  always_comb begin
    unique case (na_field[mseq_pkg::CGRP_LSB +: 2])
      2'd0: case_val = cond_inputs[3:0];
      2'd1: case_val = cond_inputs[7:4];
      2'd2: case_val = {sign_flag, overflow_flag, zero_flag, carry_flag};
      2'd3: case_val = {in_irq, block_count_zero, fifo_out_ready, fifo_mem[rd_ptr][21]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts and next address
  assign irq_pend = {stack_full_flag & ~in_irq & (sp == 4'(STACK_DEPTH)),
                     (pc == brk_addr),
                     int_irq_b, int_irq_a,
                     irq_en & ext_s2 & ~ext_s3};

  always_comb begin
    next_pc = pc + 10'h001;
    if (!in_irq && irq_pend != 8'h00) begin
      next_pc = mseq_pkg::EXT_VEC_BASE;
      for (int i = 7; i >= 0; i--) begin
        if (irq_pend[i]) next_pc = mseq_pkg::EXT_VEC_BASE + 10'(i);
      end
    end else begin
      unique case (na_op)
        mseq_pkg::NA_JUMP: next_pc = target;
        mseq_pkg::NA_JCOND: next_pc = cond_bit ? target : pc + 10'h001;
        mseq_pkg::NA_CASE: next_pc = target | {6'h00, case_val};
        mseq_pkg::NA_CALL: next_pc = target;
        mseq_pkg::NA_RET, mseq_pkg::NA_RETI: next_pc = stack_mem[sp - 4'h1];
        mseq_pkg::NA_ENDLOOP: next_pc = (loop_count != 16'h0001) ? target : pc + 10'h001;
        mseq_pkg::NA_FIFO_CMD: next_pc = fifo_out_ready ? fifo_mem[rd_ptr][9:0] : pc;
        default: next_pc = pc + 10'h001;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc <= mseq_pkg::RESET_PC;
    else pc <= next_pc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stack and loop counter
  logic take_irq;
  assign take_irq = !in_irq && irq_pend != 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= 4'h0;
      loop_count <= 16'h0000;
      in_irq <= 1'b0;
    end else if (take_irq) begin
      in_irq <= 1'b1;
      if (sp != 4'(STACK_DEPTH)) begin
        stack_mem[sp] <= pc;
        sp <= sp + 4'h1;
      end
    end else begin
      unique case (na_op)
        mseq_pkg::NA_CALL: if (sp != 4'(STACK_DEPTH)) begin
          stack_mem[sp] <= pc + 10'h001;
          sp <= sp + 4'h1;
        end
        mseq_pkg::NA_RET, mseq_pkg::NA_RETI: begin
          if (sp != 4'h0) sp <= sp - 4'h1;
          if (na_op == mseq_pkg::NA_RETI) in_irq <= 1'b0;
        end
        mseq_pkg::NA_LOOP: begin
          if (sp != 4'(STACK_DEPTH)) begin
            stack_mem[sp] <= loop_count[9:0];
            sp <= sp + 4'h1;
          end
          loop_count <= {6'h00, target};
        end
        mseq_pkg::NA_ENDLOOP: if (loop_count != 16'h0001) loop_count <= loop_count - 16'h0001;
        else begin
          loop_count <= {6'h00, stack_mem[sp - 4'h1]};
          if (sp != 4'h0) sp <= sp - 4'h1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host FIFO
  assign host_wr_pulse = !hs2[2] && !hs2[0] && hs3[0] && hs2[1];
  assign fifo_in_ready = fifo_count != 4'(FIFO_DEPTH);
  assign fifo_out_ready = fifo_count != 4'h0;
  assign fifo_push = host_wr_pulse && fifo_in_ready;
  assign fifo_pop = fifo_out_ready && !take_irq &&
                    (na_op == mseq_pkg::NA_FIFO_CMD || na_op == mseq_pkg::NA_FIFO_DATA);
  assign fifo_out_data = fifo_mem[rd_ptr][15:0];
  assign fifo_out_addr = fifo_mem[rd_ptr][20:16];
  assign gpio7_fifo_in_ready = fifo_in_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      fifo_count <= 4'h0;
    end else begin
      if (fifo_push) begin
        fifo_mem[wr_ptr] <= hd2;
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (fifo_pop) rd_ptr <= rd_ptr + 3'h1;
      fifo_count <= fifo_count + 4'(fifo_push) - 4'(fifo_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_exception_flag <= 1'b0;
      stack_full_flag <= 1'b0;
      brk_flag <= 1'b0;
    end else begin
      if (fifo_pop && (fifo_mem[rd_ptr][21] != (na_op == mseq_pkg::NA_FIFO_CMD)))
        fifo_exception_flag <= 1'b1;
      else if (apb_wr && paddr == mseq_pkg::REG_STATUS_CLR && pwdata[mseq_pkg::ST_FIFO_EXCEPTION_FLAG])
        fifo_exception_flag <= 1'b0;
      stack_full_flag <= (sp == 4'(STACK_DEPTH));
      if (pc == brk_addr) brk_flag <= 1'b1;
      else if (apb_wr && paddr == mseq_pkg::REG_STATUS_CLR && pwdata[mseq_pkg::ST_BRK])
        brk_flag <= 1'b0;
    end
  end

  always_comb begin
    status_word = mseq_pkg::STATUS_RESET;
    status_word[mseq_pkg::ST_SEC] = security_on;
    status_word[mseq_pkg::ST_SCAN] = scan_mode_on;
    status_word[mseq_pkg::ST_FIFO_EXCEPTION_FLAG] = fifo_exception_flag;
    status_word[mseq_pkg::ST_FIFO_IN_READY] = fifo_in_ready;
    status_word[mseq_pkg::ST_CY] = carry_flag;
    status_word[mseq_pkg::ST_Z] = zero_flag;
    status_word[mseq_pkg::ST_OV] = overflow_flag;
    status_word[mseq_pkg::ST_SGN] = sign_flag;
    status_word[mseq_pkg::ST_STACK_FULL_FLAG] = stack_full_flag;
    status_word[mseq_pkg::ST_BRK] = brk_flag;
    status_word[mseq_pkg::ST_BCZ] = block_count_zero;
    status_word[mseq_pkg::ST_ACO] = addr_count_all_ones;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data input register and host bus source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) data_in_reg <= 16'h0000;
    else if (out_ctrl[mseq_pkg::CTRL_DATA_IN_CAPTURE_EN]) data_in_reg <= data_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_out <= 16'h0000;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= (hs2 == 3'h7) && (out_ctrl[6:5] != 2'b00);
      unique case ({out_ctrl[mseq_pkg::CTRL_HSEL1], out_ctrl[mseq_pkg::CTRL_HSEL0]})
        2'b01: host_data_out <= data_out_reg;
        2'b10: host_data_out <= status_word;
        2'b11: host_data_out <= {6'h00, pc};
        default: host_data_out <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_addr <= mseq_pkg::BRK_RESET;
      irq_en <= 4'h0;
      prog_addr <= 10'h000;
      prog_lo <= 32'h00000000;
      data_out_reg <= 16'h0000;
    end else if (apb_wr) begin
      unique case (paddr)
        mseq_pkg::REG_BRK: brk_addr <= pwdata[9:0];
        mseq_pkg::REG_IRQ_EN: irq_en <= pwdata[3:0];
        mseq_pkg::REG_PROG_ADDR: prog_addr <= pwdata[9:0];
        mseq_pkg::REG_PROG_DATA0: prog_lo <= pwdata;
        mseq_pkg::REG_PROG_DATA1: begin
          prog_mem[prog_addr] <= {pwdata, prog_lo};
          prog_addr <= prog_addr + 10'h001;
        end
        mseq_pkg::REG_DOR: data_out_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (apb_rd && !penable) begin
      unique case (paddr)
        mseq_pkg::REG_STATUS: prdata <= {16'h0000, status_word};
        mseq_pkg::REG_PC: prdata <= {22'h000000, pc};
        mseq_pkg::REG_BRK: prdata <= {22'h000000, brk_addr};
        mseq_pkg::REG_IRQ_EN: prdata <= {28'h0000000, irq_en};
        mseq_pkg::REG_PROG_ADDR: prdata <= {22'h000000, prog_addr};
        mseq_pkg::REG_DOR: prdata <= {16'h0000, data_out_reg};
        mseq_pkg::REG_DIR: prdata <= {16'h0000, data_in_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_pc: assert property (@(posedge pclk) $rose(presetn) |-> pc == 10'h000)
    else $error("pc not zero after reset");
  a_fifo_full_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (fifo_count == 4'h8 && !fifo_pop) |=> fifo_count == 4'h8)
    else $error("fifo count changed while full");
  a_ready_flags: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_out_ready == (fifo_count != 4'h0) && gpio7_fifo_in_ready == (fifo_count < 4'h8))
    else $error("fifo ready flags wrong");
  a_brk_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (pc == brk_addr && !in_irq && irq_pend[5:0] == 6'h00) |=> pc == 10'h00e)
    else $error("breakpoint vector missed");
  a_brk_flag: assert property (@(posedge pclk) disable iff (!presetn)
    pc == brk_addr |=> status_word[2])
    else $error("breakpoint flag not set");
  a_cmd_redirect: assert property (@(posedge pclk) disable iff (!presetn)
    (fifo_pop && na_op == mseq_pkg::NA_FIFO_CMD) |=> pc == $past(fifo_out_data[9:0]))
    else $error("command redirect wrong");
  a_fifo_exception_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (fifo_pop && na_op == mseq_pkg::NA_FIFO_DATA && fifo_mem[rd_ptr][21]) |=> status_word[9])
    else $error("exception flag not set");
  a_dir_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !out_ctrl[7] |=> $stable(data_in_reg))
    else $error("data input changed while disabled");
  a_dor_drive: assert property (@(posedge pclk) disable iff (!presetn)
    host_data_oe |-> $past(hs2) == 3'h7)
    else $error("host bus driven while strobed");
  a_ext_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (!in_irq && irq_pend[0] && irq_pend[7:1] == 7'h00) |=> pc == 10'h008)
    else $error("external vector wrong");
  a_stack_full_flag_flag: assert property (@(posedge pclk) disable iff (!presetn)
    sp == 4'(STACK_DEPTH) |=> status_word[3])
    else $error("stack full flag missing");
endmodule : mseq_top

// ### hdl/mseq_pkg.sv
// Constants for the microprogram sequencer and its host FIFO.
// Assumes a single pclk domain; imported nowhere, always scoped.
package mseq_pkg;
  localparam int unsigned PROG_DEPTH = 1024;
  localparam int unsigned WORD_W = 64;
  localparam logic [9:0] RESET_PC = 10'h000;
  localparam logic [9:0] EXT_VEC_BASE = 10'h008;
  localparam logic [9:0] INT_VEC_BASE = 10'h00c;
  localparam int unsigned STACK_DEPTH = 15;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_W = 22;
  // Instruction fields
  localparam int unsigned NA_LSB = 0;
  localparam int unsigned OC_LSB = 24;
  localparam int unsigned OP_LSB = 34;
  // Next address field: [3:0] op, [13:4] target, [16:14] cond select, [18:17] case group, [23:19] spare
  localparam int unsigned TGT_LSB = 4;
  localparam int unsigned CSEL_LSB = 14;
  localparam int unsigned CGRP_LSB = 17;
  // Output control bits
  localparam int unsigned CTRL_DATA_IN_CAPTURE_EN = 7;
  localparam int unsigned CTRL_HSEL1 = 6;
  localparam int unsigned CTRL_HSEL0 = 5;
  // Status bits
  localparam int unsigned ST_SEC = 11;
  localparam int unsigned ST_SCAN = 10;
  localparam int unsigned ST_FIFO_EXCEPTION_FLAG = 9;
  localparam int unsigned ST_FIFO_IN_READY = 8;
  localparam int unsigned ST_CY = 7;
  localparam int unsigned ST_Z = 6;
  localparam int unsigned ST_OV = 5;
  localparam int unsigned ST_SGN = 4;
  localparam int unsigned ST_STACK_FULL_FLAG = 3;
  localparam int unsigned ST_BRK = 2;
  localparam int unsigned ST_BCZ = 1;
  localparam int unsigned ST_ACO = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // APB map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PC = 8'h04;
  localparam logic [7:0] REG_BRK = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0c;
  localparam logic [7:0] REG_PROG_ADDR = 8'h10;
  localparam logic [7:0] REG_PROG_DATA0 = 8'h14;
  localparam logic [7:0] REG_PROG_DATA1 = 8'h18;
  localparam logic [7:0] REG_DOR = 8'h1c;
  localparam logic [7:0] REG_STATUS_CLR = 8'h20;
  localparam logic [7:0] REG_DIR = 8'h24;
  localparam logic [9:0] BRK_RESET = 10'h3ff;
  typedef enum logic [3:0] {
    NA_CONT = 4'h0,
    NA_JUMP = 4'h1,
    NA_JCOND = 4'h2,
    NA_CASE = 4'h3,
    NA_CALL = 4'h4,
    NA_RET = 4'h5,
    NA_LOOP = 4'h6,
    NA_ENDLOOP = 4'h7,
    NA_FIFO_CMD = 4'h8,
    NA_FIFO_DATA = 4'h9,
    NA_RETI = 4'ha
  } mseq_op_type;
endpackage : mseq_pkg

// ### tb/mseq_host_model.sv
// Host processor model that writes words into the host FIFO.
// Assumes the device samples the host strobes through synchronisers.
`timescale 1ns/1ps
module mseq_host_model (
  // Clock and ready pin
  input wire logic pclk,
  input wire logic gpio7_fifo_in_ready,
  // Host bus
  output logic host_select_n,
  output logic host_read_n,
  output logic host_write_n,
  output logic [4:0] host_addr_lines,
  output logic host_cmd_flag_line,
  output logic [15:0] host_data_in
);
  initial begin
    host_select_n = 1'b1;
    host_read_n = 1'b1;
    host_write_n = 1'b1;
    host_addr_lines = 5'h00;
    host_cmd_flag_line = 1'b0;
    host_data_in = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  task automatic send(input logic c, input logic [4:0] a, input logic [15:0] d, input logic poll);
    int n;
    n = 0;
    while (poll && gpio7_fifo_in_ready !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    host_cmd_flag_line <= c;
    host_addr_lines <= a;
    host_data_in <= d;
    host_select_n <= 1'b0;
    repeat (3) @(posedge pclk);
    host_write_n <= 1'b0;
    repeat (4) @(posedge pclk);
    host_write_n <= 1'b1;
    host_select_n <= 1'b1;
    host_data_in <= ~d;
    host_addr_lines <= ~a;
    host_cmd_flag_line <= ~c;
    repeat (3) @(posedge pclk);
  endtask : send
endmodule : mseq_host_model

// ### tb/tb_top.sv
// Testbench for the sequencer: program load, FIFO, interrupts, status.
// Assumes an APB slave with pready high and the host model above.
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_data_oe, gpio7, fifo_out_ready, fifo_in_ready;
  logic [7:0] paddr, cond_inputs;
  logic [31:0] pwdata, prdata, rd;
  logic host_select_n, host_read_n, host_write_n, host_cmd_flag_line;
  logic [4:0] host_addr_lines, fifo_out_addr;
  logic [15:0] host_data_in, host_data_out, data_in, data_in_reg, fifo_out_data;
  logic [3:0] ext_irq;
  logic [9:0] pc, out_ctrl;
  logic carry_flag, zero_flag, overflow_flag, sign_flag, security_on;
  int mismatches, samples_checked, cycles;
  mseq_top mseq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_select_n(host_select_n), .host_read_n(host_read_n), .host_write_n(host_write_n),
    .host_addr_lines(host_addr_lines), .host_cmd_flag_line(host_cmd_flag_line), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .gpio7_fifo_in_ready(gpio7),
    .ext_irq(ext_irq), .cond_inputs(cond_inputs), .int_irq_a(1'b0), .int_irq_b(1'b0), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .overflow_flag(overflow_flag), .sign_flag(sign_flag), .block_count_zero(1'b1),
    .addr_count_all_ones(1'b0), .security_on(security_on), .scan_mode_on(1'b0), .data_in(data_in), .pc(pc),
    .out_ctrl(out_ctrl), .op_field(), .data_in_reg(data_in_reg), .fifo_out_data(fifo_out_data),
    .fifo_out_addr(fifo_out_addr), .fifo_out_ready(fifo_out_ready), .fifo_in_ready(fifo_in_ready));
  mseq_host_model mseq_host_model_inst (.pclk(pclk), .gpio7_fifo_in_ready(gpio7), .host_select_n(host_select_n),
    .host_read_n(host_read_n), .host_write_n(host_write_n), .host_addr_lines(host_addr_lines),
    .host_cmd_flag_line(host_cmd_flag_line), .host_data_in(host_data_in));
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [63:0] ins(input mseq_pkg::mseq_op_type op, input logic [9:0] t, input logic [9:0] oc);
    return (64'(oc) << mseq_pkg::OC_LSB) | (64'(t) << mseq_pkg::TGT_LSB) | 64'(op);
  endfunction : ins
  task automatic load(input logic [9:0] a, input logic [63:0] w);
    apb(1'b1, mseq_pkg::REG_PROG_ADDR, {22'h0, a});
    apb(1'b1, mseq_pkg::REG_PROG_DATA0, w[31:0]);
    apb(1'b1, mseq_pkg::REG_PROG_DATA1, w[63:32]);
  endtask : load
  task automatic wait_pc(input logic [9:0] a);
    int n;
    n = 0;
    while (pc !== a && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check({22'h0, pc}, {22'h0, a});
  endtask : wait_pc
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check({22'h0, pc}, 32'h0);
    check({fifo_out_ready, fifo_in_ready, host_data_oe}, 32'h2);
    presetn <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////
  task automatic run_program;
    load(10'h000, ins(mseq_pkg::NA_CONT, 10'h000, 10'h000));
    load(10'h001, ins(mseq_pkg::NA_JCOND, 10'h003, 10'h000) | 64'h0);
    load(10'h002, ins(mseq_pkg::NA_JUMP, 10'h001, 10'h000));
    load(10'h003, ins(mseq_pkg::NA_FIFO_CMD, 10'h000, 10'h000));
    load(10'h008, ins(mseq_pkg::NA_RETI, 10'h000, 10'h000));
    load(10'h00e, ins(mseq_pkg::NA_JUMP, 10'h00e, 10'h000));
    load(10'h040, ins(mseq_pkg::NA_JUMP, 10'h040, 10'h0a0));
    do_reset();
    repeat (10) @(posedge pclk);
    apb(1'b0, mseq_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h09a2);
    {carry_flag, zero_flag, overflow_flag, sign_flag, security_on} <= 5'b01010;
    apb(1'b0, mseq_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0152);
    check({16'h0, data_in_reg}, 32'h0);
    mseq_host_model_inst.send(1'b1, 5'h03, 16'hfc40, 1'b1);
    check({fifo_out_ready, fifo_out_addr}, 32'h23);
    cond_inputs <= 8'h01;
    wait_pc(10'h040);
    check({22'h0, out_ctrl}, 32'h0a0);
    @(posedge pclk);
    #1;
    check({fifo_out_ready, 16'h0, data_in_reg}, 32'h0beef);
    apb(1'b1, mseq_pkg::REG_DOR, 32'h1234);
    repeat (3) @(posedge pclk);
    check({host_data_oe, host_data_out}, 32'h11234);
  endtask : run_program
  task automatic run_irq;
    apb(1'b1, mseq_pkg::REG_IRQ_EN, 32'h1);
    ext_irq <= 4'h2;
    repeat (10) @(posedge pclk);
    check({22'h0, pc}, 32'h040);
    ext_irq <= 4'h3;
    wait_pc(10'h008);
    wait_pc(10'h040);
    ext_irq <= 4'h0;
  endtask : run_irq
  task automatic run_fill;
    for (int i = 0; i < 9; i++) begin
      mseq_host_model_inst.send(1'b0, 5'(i), 16'h0a00 + 16'(i), 1'b0);
    end
    check({fifo_in_ready, gpio7, fifo_out_data}, 32'h0a00);
    apb(1'b1, mseq_pkg::REG_BRK, 32'h040);
    wait_pc(10'h00e);
    apb(1'b0, mseq_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h4, 32'h4);
  endtask : run_fill
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    {mismatches, samples_checked, cycles} = '0;
    {psel, penable, pwrite, paddr, pwdata, ext_irq, cond_inputs} = '0;
    {carry_flag, zero_flag, overflow_flag, sign_flag, security_on} = 5'b10101;
    presetn = 1'b0;
    data_in = 16'hbeef;
    do_reset();
    run_program();
    run_irq();
    run_fill();
    finish_test();
  end
endmodule : tb_top
